// file: src/delay_timer_pkg.sv
// Purpose: Shared constants for the delayed event timer channel.
// Assumes: Byte-wide shared-memory port, big-endian multi-byte fields.
// Notes:   Board area sits at offset zero, one channel block at ccb_base.
package delay_timer_pkg;
  // Clock rate, derived from the period
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CLK_HZ        = 1000000000 / CLK_PERIOD_NS;
  localparam logic [26:0] CLK_HZ_W      = 27'(CLK_HZ);
  // Float layout: bias plus mantissa bits
  localparam logic [7:0]  FLT_UNITY_EXP = 8'h96;
  localparam logic [7:0]  FLT_EXP_MAX   = 8'hff;

  // Board-wide locations
  localparam logic [15:0] ADDR_CMD_HI   = 16'h0004;
  localparam logic [15:0] ADDR_CMD_LO   = 16'h0005;
  localparam logic [15:0] ADDR_CMD_STAT = 16'h0007;
  localparam logic [15:0] ADDR_CHAN_SEL = 16'h000a;
  localparam logic [15:0] ADDR_ACQ_MODE = 16'h000b;
  localparam logic [15:0] ADDR_VALID    = 16'h0010;
  localparam logic [15:0] CCB_BASE      = 16'h0100;

  // Offsets inside the channel control block
  localparam logic [7:0] CCB_EDGE       = 8'h01;
  localparam logic [7:0] CCB_IRQ_LEVEL  = 8'h02;
  localparam logic [7:0] CCB_IRQ_VECTOR = 8'h03;
  localparam logic [7:0] CCB_DELAY      = 8'h04;
  localparam logic [7:0] CCB_REPEAT     = 8'h08;
  localparam logic [7:0] CCB_SUPPRESS   = 8'h09;
  localparam logic [7:0] CCB_STATUS     = 8'h0c;
  localparam logic [7:0] CCB_MEAS       = 8'h0e;

  // Command codes
  localparam logic [7:0] CMD_DELAY_TIMER = 8'h25;
  localparam logic [7:0] CMD_CLEAR_STAT  = 8'h0f;
  localparam logic [7:0] CMD_READ_COUNT  = 8'h30;
  localparam logic [7:0] CMD_DISABLE     = 8'h0e;

  // Status codes
  localparam logic [7:0] STAT_ACK        = 8'h01;
  localparam logic [7:0] STAT_MEAS_READY = 8'h02;
  localparam logic [7:0] STAT_ALARM      = 8'h08;
  localparam logic [7:0] STAT_BOUNDS     = 8'h0b;
  localparam logic [7:0] STAT_BAD_CMD    = 8'h0d;

  // Special flag values
  localparam logic [7:0] IRQ_PULSE_ONLY  = 8'hff;
  localparam logic [7:0] ACQ_CONTINUOUS  = 8'hff;
  localparam logic [7:0] VALID_SET       = 8'hff;

  // Timer sequencing states
  typedef enum logic [2:0] {
    T_IDLE, T_WAIT_EDGE, T_COUNTING, T_RETRIG_LOAD, T_RETRIG_START, T_DONE
  } timer_state_type;

  // Continuous update steps
  typedef enum logic [1:0] {REP_IDLE, REP_WRITE, REP_SET} report_step_type;
endpackage

// file: src/gate_edge_detect.sv
// Purpose: Picks the active edge of the gate input.
// Assumes: Gate input already synchronous to clk.
// Notes:   Edge pulse is combinational from one history flop.
`timescale 1ns/1ps
module gate_edge_detect (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic gate_in,
  input  wire logic rising_sel,
  output logic      edge_pulse
);
  logic prev_q; // Gate level one cycle ago

  // Gate history
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= gate_in;
    end
  end

  assign edge_pulse = rising_sel ? (gate_in & ~prev_q) : (~gate_in & prev_q);
endmodule

// file: src/float_to_cycles.sv
// Purpose: Turns a single-precision delay in seconds into clock cycles.
// Assumes: Input stable for a cycle before use; result registered.
// Notes:   Truncates; saturates at all ones rather than wrapping.
`timescale 1ns/1ps
module float_to_cycles
  import delay_timer_pkg::*;
#(
  parameter int CW = 32
) (
  input  wire logic          clk,
  input  wire logic          resetn,
  input  wire logic [31:0]   delay_float,
  output logic      [CW-1:0] cycles_q,
  output logic               bad_q
);
  logic [7:0]  expo;     // Biased exponent
  logic [23:0] mant;     // Mantissa with hidden one
  logic [50:0] prod;     // Mantissa times clock rate
  logic [50:0] shifted;  // Product scaled to whole cycles
  logic        too_big;  // Result past counter range
  logic        bad;      // Negative, zero, NaN or infinite

  assign expo    = delay_float[30:23];
  assign mant    = {1'b1, delay_float[22:0]};
  assign prod    = 51'(mant) * 51'(CLK_HZ_W);
  // Exponent above unity means the product only grows past the range
  assign shifted = (expo > FLT_UNITY_EXP) ? prod : (prod >> (FLT_UNITY_EXP - expo));
  assign too_big = (expo > FLT_UNITY_EXP) || (shifted[50:CW] != '0);
  assign bad     = delay_float[31] || (expo == FLT_EXP_MAX) || (expo == 8'h00)
                   || (!too_big && shifted[CW-1:0] == '0);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cycles_q <= '0;
      bad_q    <= 1'b1;
    end else begin
      cycles_q <= too_big ? '1 : shifted[CW-1:0];
      bad_q    <= bad;
    end
  end
endmodule

// file: src/delay_event_timer.sv
// Purpose: One counter channel run as an edge-triggered delay timer.
// Assumes: Shared-memory port is byte wide, one access per cycle.
// Notes:   Delay recomputed from the block every cycle; armed by command.
`timescale 1ns/1ps
module delay_event_timer
  import delay_timer_pkg::*;
#(
  parameter logic [7:0] CHANNEL = 8'h00, // This channel's number
  parameter int         CW      = 32     // Delay counter width
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [15:0] host_addr,
  input  wire logic [7:0]  host_wdata,
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  output logic      [7:0]  host_rdata,
  input  wire logic        gate_in,
  output logic             trig_pulse,
  output logic             irq_req,
  output logic      [7:0]  irq_level,
  output logic      [7:0]  irq_vector,
  output logic             queue_push,
  output logic      [7:0]  queue_channel,
  output logic      [7:0]  queue_code
);
  import delay_timer_pkg::*;

  // Address of one block field
  function automatic logic ccb_hit(input logic [15:0] a, input logic [7:0] off);
    return a == (CCB_BASE + 16'(off));
  endfunction

  // Shared-memory contents
  logic [7:0]  edge_sel_q, irq_level_q, irq_vector_q; // Block parameters
  logic [31:0] delay_q;                               // Float delay
  logic [7:0]  repeat_q, suppress_q;                  // Mode flags
  logic [7:0]  status_q, status_d;                    // Channel status
  logic [15:0] cmd_q;                                 // Command word
  logic [7:0]  cmd_status_q;                          // Command status
  logic [7:0]  chan_sel_q, acq_mode_q;                // Board selectors
  logic [7:0]  valid_q;                               // Data-valid flag
  logic [15:0] meas_q;                                // Reported count
  // Timer core
  timer_state_type state_q, state_d;
  report_step_type rep_q;
  logic [CW-1:0]   cnt_q, cnt_d;       // Remaining cycles
  logic [CW-1:0]   elapsed_q;          // Saved on retrigger, internal only
  logic [15:0]     expiries_q;         // Alarms since arming
  logic [CW-1:0]   delay_cycles;       // Converted delay
  logic            delay_bad;          // Delay out of range
  logic            gate_edge;          // Active edge this cycle
  // Decode
  logic wr_cmd, cmd_mine, do_arm, do_read, do_disable, do_clear, expire;
  logic continuous, use_irq, status_clear_wr;

  float_to_cycles #(.CW(CW)) conv (
    .clk         (clk),
    .resetn      (resetn),
    .delay_float (delay_q),
    .cycles_q    (delay_cycles),
    .bad_q       (delay_bad)
  );

  gate_edge_detect edet (
    .clk        (clk),
    .resetn     (resetn),
    .gate_in    (gate_in),
    .rising_sel (edge_sel_q != 8'h00),
    .edge_pulse (gate_edge)
  );

  // Command decode; clear acts for any channel, other commands for other channels pass by
  assign wr_cmd     = host_wr && host_addr == ADDR_CMD_LO;
  assign cmd_mine   = chan_sel_q == CHANNEL;
  assign do_clear   = wr_cmd && host_wdata == CMD_CLEAR_STAT;
  assign do_arm     = wr_cmd && cmd_mine && host_wdata == CMD_DELAY_TIMER && !delay_bad;
  assign do_read    = wr_cmd && cmd_mine && host_wdata == CMD_READ_COUNT;
  assign do_disable = wr_cmd && cmd_mine && host_wdata == CMD_DISABLE;
  assign continuous = acq_mode_q == ACQ_CONTINUOUS;
  assign expire     = state_q == T_COUNTING && cnt_q == CW'(1);
  // interrupt only when level and vector both set
  assign use_irq    = irq_level_q != 8'h00 && irq_vector_q != 8'h00;
  assign status_clear_wr = host_wr && ccb_hit(host_addr, CCB_STATUS);

  // Timer sequencing
  always_comb begin
    state_d = state_q;
    cnt_d   = (state_q == T_COUNTING) ? cnt_q - CW'(1) : cnt_q;
    unique case (state_q)
      T_IDLE, T_DONE: begin
        // Wait for a fresh command
      end
      T_WAIT_EDGE: begin
        if (gate_edge) begin
          state_d = T_COUNTING;
          cnt_d   = delay_cycles;
        end
      end
      T_COUNTING: begin
        if (expire) begin
          state_d = (repeat_q != 8'h00) ? T_WAIT_EDGE : T_DONE;
        end else if (gate_edge && suppress_q == 8'h00) begin
          state_d = T_RETRIG_LOAD;
        end
      end
      T_RETRIG_LOAD: begin
        if (gate_edge) begin
          state_d = T_RETRIG_START;
          cnt_d   = delay_cycles;
        end
      end
      T_RETRIG_START: begin
        if (gate_edge) begin
          state_d = T_COUNTING;
        end
      end
    endcase
    if (do_arm) begin
      state_d = T_WAIT_EDGE;
    end else if (do_disable) begin
      state_d = T_IDLE;
    end
  end

  // Timer registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q    <= T_IDLE;
      cnt_q      <= '0;
      elapsed_q  <= '0;
      expiries_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      if (state_q == T_COUNTING && state_d == T_RETRIG_LOAD) begin
        elapsed_q <= delay_cycles - cnt_q;
      end
      if (do_arm) begin
        expiries_q <= '0;
      end else if (expire) begin
        expiries_q <= expiries_q + 16'h0001;
      end
    end
  end

  // alarm written at delay end, wins over host write
  // otherwise only a host status write or a refused arm command (bounds code) changes it
  always_comb begin
    status_d = status_q;
    if (status_clear_wr) begin
      status_d = host_wdata;
    end
    if (wr_cmd && cmd_mine && host_wdata == CMD_DELAY_TIMER && delay_bad) begin
      status_d = STAT_BOUNDS;
    end
    if (expire) begin
      status_d = STAT_ALARM;
    end
  end

  // Host-written block and board fields
  always_ff @(posedge clk) begin
    if (!resetn) begin
      edge_sel_q   <= 8'h00;
      irq_level_q  <= 8'h00;
      irq_vector_q <= 8'h00;
      delay_q      <= 32'h0000_0000;
      repeat_q     <= 8'h00;
      suppress_q   <= 8'h00;
      chan_sel_q   <= 8'h00;
      acq_mode_q   <= 8'h00;
      cmd_q        <= 16'h0000;
      status_q     <= 8'h00;
    end else begin
      status_q <= status_d;
      if (host_wr) begin
        if (ccb_hit(host_addr, CCB_EDGE))       edge_sel_q     <= host_wdata;
        if (ccb_hit(host_addr, CCB_IRQ_LEVEL))  irq_level_q    <= host_wdata;
        if (ccb_hit(host_addr, CCB_IRQ_VECTOR)) irq_vector_q   <= host_wdata;
        if (ccb_hit(host_addr, CCB_DELAY))      delay_q[31:24] <= host_wdata;
        if (ccb_hit(host_addr, CCB_DELAY + 8'h01)) delay_q[23:16] <= host_wdata;
        if (ccb_hit(host_addr, CCB_DELAY + 8'h02)) delay_q[15:8]  <= host_wdata;
        if (ccb_hit(host_addr, CCB_DELAY + 8'h03)) delay_q[7:0]   <= host_wdata;
        if (ccb_hit(host_addr, CCB_REPEAT))     repeat_q       <= host_wdata;
        if (ccb_hit(host_addr, CCB_SUPPRESS))   suppress_q     <= host_wdata;
        if (host_addr == ADDR_CHAN_SEL)         chan_sel_q     <= host_wdata;
        if (host_addr == ADDR_ACQ_MODE)         acq_mode_q     <= host_wdata;
        if (host_addr == ADDR_CMD_HI)           cmd_q[15:8]    <= host_wdata;
        if (host_addr == ADDR_CMD_LO)           cmd_q[7:0]     <= host_wdata;
      end
    end
  end

  // Command status answer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cmd_status_q <= 8'h00;
    end else if (do_clear) begin
      cmd_status_q <= 8'h00;
    end else if (do_read) begin
      cmd_status_q <= STAT_MEAS_READY;
    end else if (wr_cmd && cmd_mine) begin
      cmd_status_q <= (host_wdata == CMD_DELAY_TIMER || host_wdata == CMD_DISABLE)
                      ? STAT_ACK : STAT_BAD_CMD;
    end
  end

  // clear valid, write data, set valid
  // each alarm seen in REP_IDLE refreshes the block in continuous mode
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rep_q   <= REP_IDLE;
      valid_q <= 8'h00;
      meas_q  <= 16'h0000;
    end else begin
      unique case (rep_q)
        REP_IDLE: begin
          if (expire && continuous) begin
            valid_q <= 8'h00;
            rep_q   <= REP_WRITE;
          end else if (host_wr && host_addr == ADDR_VALID) begin
            valid_q <= host_wdata;
          end
        end
        REP_WRITE: begin
          meas_q <= expiries_q;
          rep_q  <= REP_SET;
        end
        REP_SET: begin
          valid_q <= VALID_SET;
          rep_q   <= REP_IDLE;
        end
        default: rep_q <= REP_IDLE;
      endcase
      if (do_read) begin
        meas_q <= expiries_q;
      end
    end
  end

  // Expiry outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      trig_pulse    <= 1'b0;
      irq_req       <= 1'b0;
      queue_push    <= 1'b0;
      queue_code    <= 8'h00;
      queue_channel <= 8'h00;
    end else begin
      // pulse always, interrupt never when level all ones
      trig_pulse <= expire;
      irq_req    <= expire && !continuous && irq_level_q != IRQ_PULSE_ONLY && use_irq;
      // queue takes the reported expiries (not continuous, not pulse-only) that the interrupt does not
      queue_push <= expire && !continuous && irq_level_q != IRQ_PULSE_ONLY && !use_irq;
      if (expire) begin
        queue_code    <= STAT_ALARM;
        queue_channel <= CHANNEL;
      end
    end
  end

  assign irq_level  = irq_level_q;
  assign irq_vector = irq_vector_q;

  // Read data, registered; unmapped reads zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      host_rdata <= 8'h00;
    end else if (host_rd) begin
      host_rdata <= 8'h00;
      if (ccb_hit(host_addr, CCB_EDGE))           host_rdata <= edge_sel_q;
      if (ccb_hit(host_addr, CCB_IRQ_LEVEL))      host_rdata <= irq_level_q;
      if (ccb_hit(host_addr, CCB_IRQ_VECTOR))     host_rdata <= irq_vector_q;
      if (ccb_hit(host_addr, CCB_DELAY))          host_rdata <= delay_q[31:24];
      if (ccb_hit(host_addr, CCB_DELAY + 8'h01))  host_rdata <= delay_q[23:16];
      if (ccb_hit(host_addr, CCB_DELAY + 8'h02))  host_rdata <= delay_q[15:8];
      if (ccb_hit(host_addr, CCB_DELAY + 8'h03))  host_rdata <= delay_q[7:0];
      if (ccb_hit(host_addr, CCB_REPEAT))         host_rdata <= repeat_q;
      if (ccb_hit(host_addr, CCB_SUPPRESS))       host_rdata <= suppress_q;
      if (ccb_hit(host_addr, CCB_STATUS))         host_rdata <= status_q;
      if (ccb_hit(host_addr, CCB_MEAS))           host_rdata <= meas_q[15:8];
      if (ccb_hit(host_addr, CCB_MEAS + 8'h01))   host_rdata <= meas_q[7:0];
      if (host_addr == ADDR_CHAN_SEL)             host_rdata <= chan_sel_q;
      if (host_addr == ADDR_ACQ_MODE)             host_rdata <= acq_mode_q;
      if (host_addr == ADDR_CMD_HI)               host_rdata <= cmd_q[15:8];
      if (host_addr == ADDR_CMD_LO)               host_rdata <= cmd_q[7:0];
      if (host_addr == ADDR_CMD_STAT)             host_rdata <= cmd_status_q;
      if (host_addr == ADDR_VALID)                host_rdata <= valid_q;
    end
  end

  // Checks, all in the one clock domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence update_steps;
    valid_q == 8'h00 ##1 valid_q == 8'h00 ##1 valid_q == VALID_SET;
  endsequence

  alarm_status_a: assert property (expire |=> status_q == STAT_ALARM)
    else $error("alarm not written at expiry");
  status_hold_a: assert property (
    status_q == STAT_ALARM && !status_clear_wr && !wr_cmd |=> $stable(status_q))
    else $error("alarm status changed without host clear");
  pulse_only_a: assert property (
    expire && irq_level_q == IRQ_PULSE_ONLY |=> trig_pulse && !irq_req && !queue_push)
    else $error("pulse-only mode raised a report");
  cont_no_irq_a: assert property (irq_req |-> $past(acq_mode_q) != ACQ_CONTINUOUS)
    else $error("interrupt in continuous mode");
  valid_order_a: assert property (
    rep_q == REP_IDLE && expire && continuous |=> update_steps)
    else $error("valid flag sequence broken");
  suppress_edge_a: assert property (
    state_q == T_COUNTING && suppress_q != 8'h00 && gate_edge && !expire && !wr_cmd
    |=> state_q == T_COUNTING && cnt_q == $past(cnt_q) - CW'(1))
    else $error("suppressed edge disturbed count");
  retrig_save_a: assert property (
    state_q == T_COUNTING && suppress_q == 8'h00 && gate_edge && !expire && !wr_cmd
    |=> state_q == T_RETRIG_LOAD && cnt_q == $past(cnt_q) - CW'(1))
    else $error("retrigger did not enter save step");
  retrig_load_a: assert property (state_q == T_RETRIG_LOAD && gate_edge && !wr_cmd
    |=> state_q == T_RETRIG_START && cnt_q == delay_cycles)
    else $error("second retrigger edge did not load");
  report_path_a: assert property (
    expire && !continuous && irq_level_q != IRQ_PULSE_ONLY |=> irq_req != queue_push)
    else $error("expiry not reported exactly once");
  one_shot_a: assert property (expire && repeat_q == 8'h00 && !wr_cmd |=> state_q == T_DONE)
    else $error("one-shot timer kept running");
endmodule

// file: sim/host_model.sv
// Purpose: Host side of the shared-memory byte port for one channel.
// Assumes: Strobes change on the falling edge, one byte per strobe.
// Notes:   Released lines show inverted values, never a stale copy.
`timescale 1ns/1ps
module host_model
  import delay_timer_pkg::*;
(
  input  wire logic        clk,
  output logic      [15:0] host_addr,
  output logic      [7:0]  host_wdata,
  output logic             host_wr,
  output logic             host_rd,
  input  wire logic [7:0]  host_rdata
);
  logic [7:0] cs;  // Command status seen after a clear

  // Idle bus at time zero
  initial begin
    host_addr  = 16'h0000;
    host_wdata = 8'h00;
    host_wr    = 1'b0;
    host_rd    = 1'b0;
  end

  // One byte write, strobe high across one rising edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    host_addr  = a;
    host_wdata = d;
    host_wr    = 1'b1;
    @(negedge clk);
    host_wr    = 1'b0;
    host_addr  = ~a;
    host_wdata = ~d;
  endtask

  // One byte read; data taken a full cycle later, so it has settled
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    host_addr = a;
    host_rd   = 1'b1;
    @(negedge clk);
    host_rd   = 1'b0;
    host_addr = ~a;
    @(negedge clk);
    d = host_rdata;
  endtask

  // Channel block byte by offset
  task automatic wcb(input logic [7:0] o, input logic [7:0] d);
    wr(CCB_BASE + 16'(o), d);
  endtask

  // Whole timer set-up in the order the host must keep
  task automatic start(input logic [7:0] es, lv, vc, rp, sp, md, input logic [31:0] dl);
    wr(ADDR_ACQ_MODE, md);
    // clear command status, read it back
    wr(ADDR_CMD_LO, CMD_CLEAR_STAT);
    rd(ADDR_CMD_STAT, cs);
    // block fields, then channel, then command
    wcb(CCB_EDGE, es);
    wcb(CCB_IRQ_LEVEL, lv);
    wcb(CCB_IRQ_VECTOR, vc);
    wcb(CCB_REPEAT, rp);
    wcb(CCB_SUPPRESS, sp);
    for (int i = 0; i < 4; i++) begin
      wcb(CCB_DELAY + 8'(i), dl[31-8*i -: 8]);
    end
    wcb(CCB_STATUS, 8'h00);
    wr(ADDR_CHAN_SEL, 8'h00);
    wr(ADDR_CMD_HI, 8'h00);
    wr(ADDR_CMD_LO, CMD_DELAY_TIMER);
  endtask
endmodule

// file: sim/delayed_event_timer_reporting_bench.sv
// Purpose: Self-checking bench for the delayed event timer channel.
// Assumes: Channel zero; a ten-cycle float delay keeps runs short.
// Notes:   Expiry outcomes are queued by the driver, matched by a monitor.
`timescale 1ns/1ps
module delayed_event_timer_reporting_bench;
  import delay_timer_pkg::*;
  // Expected outcome of one expiry
  typedef struct packed {
    logic       irq;
    logic       push;
    logic [7:0] lvl;
    logic [7:0] vec;
  } note_type;
  localparam int          LIMIT = 20000;         // Cycle ceiling
  localparam logic [31:0] D10   = 32'h33d6bf95;  // Just over 1e-7 s
  localparam logic [15:0] STA   = CCB_BASE + 16'(CCB_STATUS);
  localparam logic [15:0] MLO   = CCB_BASE + 16'(CCB_MEAS) + 16'h0001;
  logic        clk;
  logic        resetn;
  logic        gate_in;
  logic        cont_phase;                       // Continuous run active
  logic [15:0] host_addr;
  logic [7:0]  host_wdata, host_rdata, irq_level, irq_vector, queue_channel, queue_code;
  logic        host_wr, host_rd, trig_pulse, irq_req, queue_push;
  int          n_fail, n_checks, cyc, t0, t1, lat, seed;
  logic [7:0]  st, lv, vc, es;
  note_type    notes[$];
  note_type    nt;

  delay_event_timer uut (
    .clk(clk), .resetn(resetn), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata), .gate_in(gate_in),
    .trig_pulse(trig_pulse), .irq_req(irq_req), .irq_level(irq_level),
    .irq_vector(irq_vector), .queue_push(queue_push), .queue_channel(queue_channel),
    .queue_code(queue_code));
  host_model host (
    .clk(clk), .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr),
    .host_rd(host_rd), .host_rdata(host_rdata));

  // 100 MHz clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Cycle count doubles as the hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      final_report();
    end
  end

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Monitor: every expiry outside the continuous run takes the oldest note
  always @(negedge clk) begin
    if (cont_phase) begin
      if (irq_req === 1'b1 || queue_push === 1'b1) check("cont_report", 0, 1);
    end else if (trig_pulse === 1'b1) begin
      if (notes.size() == 0) begin
        check("spare_pulse", 0, 1);
      end else begin
        nt = notes.pop_front();
        check("irq_req", nt.irq, irq_req);
        check("queue_push", nt.push, queue_push);
        if (nt.irq) check("irq_level", nt.lvl, irq_level);
        if (nt.irq) check("irq_vector", nt.vec, irq_vector);
        if (nt.push) check("queue_code", STAT_ALARM, queue_code);
        if (nt.push) check("queue_chan", 8'h00, queue_channel);
      end
    end
  end

  // Active edge after a three-cycle quiet spell; edges at least four cycles apart
  // edge rate kept low
  task automatic fire(input logic rise);
    @(negedge clk);
    gate_in = ~rise;
    repeat (3) @(negedge clk);
    gate_in = rise;
    t0 = cyc;
  endtask

  // Bounded wait for the pulse, then its distance from the edge
  task automatic wait_trig();
    lat = 0;
    while (trig_pulse !== 1'b1 && lat < 100) begin
      @(negedge clk);
      lat++;
    end
    check("latency", 1, (cyc - t0 >= 11) && (cyc - t0 <= 12));
  endtask

  initial begin
    seed = 85551;
    resetn = 1'b0;
    gate_in = 1'b0;
    cont_phase = 1'b0;
    n_fail = 0;
    n_checks = 0;
    cyc = 0;
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    // Interrupt, pulse only, queue, then falling edge; all one-shot
    for (int k = 0; k < 4; k++) begin
      lv = 8'(($unsigned($random(seed)) % 7) + 1);
      vc = 8'($random(seed)) | 8'h01;
      es = (k == 3) ? 8'h00 : (8'($random(seed)) | 8'h01);
      if (k == 1 || k == 3) lv = IRQ_PULSE_ONLY;
      if (k == 2) lv = 8'h00;
      if (k == 2) vc = 8'h00;
      host.start(es, lv, vc, 8'h00, 8'h00, 8'h00, D10);
      check("cmd_clear", 8'h00, host.cs);
      host.rd(ADDR_CMD_STAT, st);
      check("cmd_ack", STAT_ACK, st);
      notes.push_back('{k == 0, k == 2, lv, vc});
      fire(es != 8'h00);
      wait_trig();
      host.rd(STA, st);
      check("alarm", STAT_ALARM, st);
      fire(es != 8'h00);
      repeat (30) @(negedge clk);
      host.rd(STA, st);
      check("alarm_held", STAT_ALARM, st);
      host.wcb(CCB_STATUS, 8'h00);
      host.rd(STA, st);
      check("alarm_ack", 8'h00, st);
      $display("Reporting mode %0d done", k);
    end
    // Retrigger: four close edges, pulse counted from the last
    host.start(8'h01, IRQ_PULSE_ONLY, 8'h00, 8'h00, 8'h00, 8'h00, D10);
    notes.push_back('{1'b0, 1'b0, IRQ_PULSE_ONLY, 8'h00});
    repeat (4) fire(1'b1);
    wait_trig();
    $display("Retrigger done");
    // Suppression with repeat: early edge ignored, later edge restarts
    host.start(8'h01, IRQ_PULSE_ONLY, 8'h00, 8'h01, 8'h01, 8'h00, D10);
    notes.push_back('{1'b0, 1'b0, IRQ_PULSE_ONLY, 8'h00});
    notes.push_back('{1'b0, 1'b0, IRQ_PULSE_ONLY, 8'h00});
    fire(1'b1);
    t1 = t0;
    fire(1'b1);
    t0 = t1;
    wait_trig();
    fire(1'b1);
    wait_trig();
    host.wr(ADDR_CMD_LO, CMD_DISABLE);
    fire(1'b1);
    repeat (30) @(negedge clk);
    host.wr(ADDR_CMD_LO, CMD_READ_COUNT);
    host.rd(ADDR_CMD_STAT, st);
    check("read_stat", STAT_MEAS_READY, st);
    host.rd(MLO, st);
    check("read_count", 8'h02, st);
    $display("Suppressed repeat done");
    // Zero delay is refused with a bounds code
    host.start(8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 32'h00000000);
    host.rd(STA, st);
    check("bounds", STAT_BOUNDS, st);
    $display("Bad delay done");
    // Continuous: valid flag and status only, never an interrupt
    cont_phase = 1'b1;
    host.start(8'h01, 8'h05, 8'h40, 8'h00, 8'h00, ACQ_CONTINUOUS, D10);
    fire(1'b1);
    repeat (20) @(negedge clk);
    host.rd(ADDR_VALID, st);
    check("valid_set", VALID_SET, st);
    host.rd(STA, st);
    check("status_set", 1, st != 8'h00);
    host.rd(MLO, st);
    check("meas_lo", 8'h01, st);
    host.wr(ADDR_VALID, 8'h00);
    host.rd(ADDR_VALID, st);
    check("valid_clr", 8'h00, st);
    cont_phase = 1'b0;
    $display("Continuous done");
    check("notes_left", 0, notes.size());
    final_report();
  end
endmodule
